// >>> pkg/inverter_pwm_pkg.sv
// Constants shared by the inverter PWM timer core and its dead-time timers
// Contract
// R1 - Carrier counter is 10-bit up/down, steps on count clock, starts upward from zero.
// R2 - Reaching zero while counting down raises underflow, underflow request, and turns upward.
// R3 - Underflow request is thinned by the divide field to one per N underflows.
// R4 - Count clock is system clock divided by 1, 2, 4, 8, 16 or 32.
// R5 - Reset or clearing counter enable forces the carrier counter to zero.
// R6 - Each phase duty compare match toggles that phase flip-flop.
// R7 - Each issued underflow request copies all six buffers into their compares.
// R8 - Duty and event compare writes take effect only while the counter is stopped.
// R9 - Period compare is written only when stopped; while running only from its buffer.
// R10 - Reset or clearing counter enable zeroes duty and event compares.
// R11 - Counter equal to period or zero reverses direction at next count clock.
// R12 - Reset sets the period compare to 0ff.
// R13 - Software never programs a period of zero.
// R14 - Each event compare match against the counter raises its own request.
// R15 - All six buffers are readable and writable whether stopped or running.
// R16 - Reset sets period buffer to 0ff and the other five buffers to zero.
// R17 - Buffers take word and byte writes; a low-byte alias serves narrow access.
// R18 - One 8-bit dead-time value feeds three timers, each loading it independently.
// R19 - Dead-time writes while running are ignored; accepted only when stopped.
// R20 - Reset sets the dead-time reload value to ff.
// R21 - A dead-time value of zero still gives one system clock of dead time.
// R22 - Six outputs in phase pairs, selectable active level, shut-off from external pin.
// R23 - Dead-time timer reloads on match, counts down, underflows 00 to ff, holds ff.
// R24 - Divide field value k issues the underflow request every k+1 underflows.
// R25 - Enable low clears and stops counters and divider; outputs go high impedance.
// R26 - Transfer divider counts underflows; reset, issued request or enable low set it to 7.
// R27 - Each output's active edge is delayed by the dead time so pairs never overlap.
package inverter_pwm_pkg;
	// Widths
	localparam int CNT_W = 10;
	localparam int DT_W  = 8;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_MODE     = 8'h04;
	localparam logic [7:0] ADDR_STAT     = 8'h08;
	localparam logic [7:0] ADDR_CMP_BASE = 8'h10;
	localparam logic [7:0] ADDR_BUF_BASE = 8'h30;
	localparam logic [7:0] ADDR_DTIME    = 8'h48;
	localparam logic [7:0] ADDR_LOW_BASE = 8'h60;
	// Field positions
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_CLK_LSB    = 3;
	localparam int CTRL_DIV_LSB    = 0;
	localparam int MODE_STATUS_BIT = 4;
	localparam int MODE_ALV_BIT    = 3;
	localparam int MODE_SHUT_BIT   = 0;
	localparam int STAT_UP_BIT     = 10;
	localparam int PERIOD_IDX      = 3;
	// Reset values
	localparam logic [9:0] CMP_RST    = 10'h000;
	localparam logic [9:0] PERIOD_RST = 10'h0ff;
	localparam logic [7:0] DTIME_RST  = 8'hff;
	localparam logic [2:0] DIV_RST    = 3'h7;
	localparam logic [7:0] DT_IDLE    = 8'hff;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> pkg/dead_time_if.sv
// Link between the core and one dead-time timer
`timescale 1ns/1ns
`default_nettype none
interface dead_time_if;
	logic [7:0] reload;
	logic       load;
	logic       run;
	logic       idle;
	modport core  (output reload, output load, output run, input idle);
	modport timer (input reload, input load, input run, output idle);
endinterface
`default_nettype wire

// >>> hw/dead_time_timer.sv
// One 8-bit dead-time down counter
`timescale 1ns/1ns
`default_nettype none
module dead_time_timer (
	// Clock and reset
	input wire logic     aclk,
	input wire logic     aresetn,
	// Core link
	dead_time_if.timer   link
);
	logic [7:0] count;
	logic       busy;

	// Reload on match, count down each clock, stop after 00 to ff wrap
	always_ff @(posedge aclk) begin
		if (!aresetn || !link.run) begin
			count <= inverter_pwm_pkg::DT_IDLE; // R25
			busy  <= 1'b0;
		end else if (link.load) begin
			count <= link.reload; // R18 R23
			busy  <= 1'b1;
		end else if (busy) begin
			count <= count - 8'h01; // R23
			if (count == 8'h00) begin
				busy <= 1'b0; // R21
			end
		end
	end

	// Idle except from a reload until the wrap has happened
	assign link.idle = !busy;

	AST_DT_WRAP: assert property (@(posedge aclk) disable iff (!aresetn) // R23
		busy && count == 8'h00 && !link.load && link.run |=> !busy && count == 8'hff)
		else $error("dead-time timer did not stop at ff after wrap");
endmodule
`default_nettype wire

// >>> hw/inverter_pwm_timer_core.sv
// Three-phase inverter PWM timer core with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
module inverter_pwm_timer_core (
	// Clock and reset
	input wire logic         aclk,
	input wire logic         aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0]   s_axi_awaddr,
	input wire logic         s_axi_awvalid,
	output logic             s_axi_awready,
	input wire logic [31:0]  s_axi_wdata,
	input wire logic [3:0]   s_axi_wstrb,
	input wire logic         s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input wire logic         s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0]   s_axi_araddr,
	input wire logic         s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input wire logic         s_axi_rready,
	// Shut-off input
	input wire logic         external_shutoff_pin,
	// Phase outputs, even positive, odd negative
	output logic [5:0]       phase_out,
	output logic [5:0]       phase_oe,
	// Event requests
	output logic             underflow_irq,
	output logic             event_irq_a,
	output logic             event_irq_b
);
	// Control and mode
	logic        counter_enable;
	logic [2:0]  clk_sel;
	logic [2:0]  irq_div;
	logic        active_high;
	logic        shutoff_arm;
	logic        out_status;
	logic        enable_q;
	logic        shutoff_q;
	// Compare, buffer and dead-time storage
	logic [9:0]  cmp [0:5];
	logic [9:0]  cmp_buf [0:5];
	logic [7:0]  dead_time_reload;
	// Counting state
	logic [9:0]  carrier_counter;
	logic        count_up;
	logic [9:0]  next_cnt;
	logic        next_up;
	logic [4:0]  prescale;
	logic [4:0]  pre_mask;
	logic        tick;
	logic        underflow;
	logic        issue;
	logic [2:0]  transfer_divider_counter;
	logic        enable_fall;
	logic [2:0]  phase_ff;
	logic [2:0]  match;
	// Bus state
	logic [7:0]  aw_addr_q;
	logic        aw_held;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_held;
	logic        wr_go;
	logic        wr_hit;
	logic [5:0]  wr_cmp;
	logic [5:0]  wr_buf;
	logic [5:0]  wr_low;
	logic [31:0] rd_data;
	logic        rd_hit;

	assign wr_go       = aw_held && w_held && !s_axi_bvalid;
	assign enable_fall = enable_q && !counter_enable;

	// Write decode of the held address
	always_comb begin
		wr_hit = (aw_addr_q == inverter_pwm_pkg::ADDR_CTRL)
			|| (aw_addr_q == inverter_pwm_pkg::ADDR_MODE)
			|| (aw_addr_q == inverter_pwm_pkg::ADDR_STAT)
			|| (aw_addr_q == inverter_pwm_pkg::ADDR_DTIME);
		for (int i = 0; i < 6; i++) begin
			wr_cmp[i] = wr_go && aw_addr_q == inverter_pwm_pkg::ADDR_CMP_BASE + 8'(4 * i);
			wr_buf[i] = wr_go && aw_addr_q == inverter_pwm_pkg::ADDR_BUF_BASE + 8'(4 * i);
			wr_low[i] = wr_go && aw_addr_q == inverter_pwm_pkg::ADDR_LOW_BASE + 8'(4 * i);
			wr_hit = wr_hit || aw_addr_q == inverter_pwm_pkg::ADDR_CMP_BASE + 8'(4 * i)
				|| aw_addr_q == inverter_pwm_pkg::ADDR_BUF_BASE + 8'(4 * i)
				|| aw_addr_q == inverter_pwm_pkg::ADDR_LOW_BASE + 8'(4 * i);
		end
	end

	// Read mux, unmapped reads give zero with an error response
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (s_axi_araddr == inverter_pwm_pkg::ADDR_CTRL) begin
			rd_data[inverter_pwm_pkg::CTRL_ENABLE_BIT] = counter_enable;
			rd_data[inverter_pwm_pkg::CTRL_CLK_LSB +: 3] = clk_sel;
			rd_data[inverter_pwm_pkg::CTRL_DIV_LSB +: 3] = irq_div;
		end else if (s_axi_araddr == inverter_pwm_pkg::ADDR_MODE) begin
			rd_data[inverter_pwm_pkg::MODE_STATUS_BIT] = out_status;
			rd_data[inverter_pwm_pkg::MODE_ALV_BIT] = active_high;
			rd_data[inverter_pwm_pkg::MODE_SHUT_BIT] = shutoff_arm;
		end else if (s_axi_araddr == inverter_pwm_pkg::ADDR_STAT) begin
			rd_data[9:0] = carrier_counter;
			rd_data[inverter_pwm_pkg::STAT_UP_BIT] = count_up;
		end else if (s_axi_araddr == inverter_pwm_pkg::ADDR_DTIME) begin
			rd_data[7:0] = dead_time_reload;
		end else begin
			rd_hit = 1'b0;
		end
		for (int i = 0; i < 6; i++) begin
			if (s_axi_araddr == inverter_pwm_pkg::ADDR_CMP_BASE + 8'(4 * i)) begin
				rd_data[9:0] = cmp[i];
				rd_hit = 1'b1;
			end
			if (s_axi_araddr == inverter_pwm_pkg::ADDR_BUF_BASE + 8'(4 * i)) begin
				rd_data[9:0] = cmp_buf[i]; // R15
				rd_hit = 1'b1;
			end
			if (s_axi_araddr == inverter_pwm_pkg::ADDR_LOW_BASE + 8'(4 * i)) begin
				rd_data[7:0] = cmp_buf[i][7:0]; // R17
				rd_hit = 1'b1;
			end
		end
	end

	// Write address and data are taken independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
		end else begin
			s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready;
			s_axi_wready  <= s_axi_wvalid && !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held   <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response once both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= inverter_pwm_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? inverter_pwm_pkg::RESP_OKAY : inverter_pwm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel, one read under way at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= inverter_pwm_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_hit ? inverter_pwm_pkg::RESP_OKAY : inverter_pwm_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control and mode registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_enable <= 1'b0;
			clk_sel        <= 3'h0;
			irq_div        <= 3'h0;
			active_high    <= 1'b0;
			shutoff_arm    <= 1'b0;
		end else if (wr_go && w_strb_q[0]) begin
			if (aw_addr_q == inverter_pwm_pkg::ADDR_CTRL) begin
				counter_enable <= w_data_q[inverter_pwm_pkg::CTRL_ENABLE_BIT];
				clk_sel        <= w_data_q[inverter_pwm_pkg::CTRL_CLK_LSB +: 3];
				irq_div        <= w_data_q[inverter_pwm_pkg::CTRL_DIV_LSB +: 3];
			end
			if (aw_addr_q == inverter_pwm_pkg::ADDR_MODE) begin
				active_high <= w_data_q[inverter_pwm_pkg::MODE_ALV_BIT]; // R22
				shutoff_arm <= w_data_q[inverter_pwm_pkg::MODE_SHUT_BIT];
			end
		end
	end

	// Dead-time reload, locked while counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dead_time_reload <= inverter_pwm_pkg::DTIME_RST; // R20
		end else if (wr_go && w_strb_q[0] && !counter_enable
			&& aw_addr_q == inverter_pwm_pkg::ADDR_DTIME) begin
			dead_time_reload <= w_data_q[7:0]; // R19
		end
	end

	// Output status: set at start, dropped by stop or an armed shut-off edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_status <= 1'b0;
			enable_q   <= 1'b0;
			shutoff_q  <= 1'b0;
		end else begin
			enable_q  <= counter_enable;
			shutoff_q <= external_shutoff_pin;
			if (!counter_enable) begin
				out_status <= 1'b0; // R25
			end else if (shutoff_arm && external_shutoff_pin && !shutoff_q) begin
				out_status <= 1'b0; // R22
			end else if (!enable_q) begin
				out_status <= 1'b1;
			end
		end
	end

	// Prescaler gives the count clock as a one-cycle enable
	assign pre_mask = 5'((6'h01 << clk_sel) - 6'h01); // R4
	assign tick     = counter_enable && ((prescale & pre_mask) == pre_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn || !counter_enable) begin
			prescale <= 5'h00;
		end else begin
			prescale <= prescale + 5'h01;
		end
	end

	// Next count and direction; a period of zero is left to software to avoid
	always_comb begin
		next_cnt = carrier_counter;
		next_up  = count_up;
		if (count_up) begin
			if (carrier_counter == cmp[inverter_pwm_pkg::PERIOD_IDX]) begin
				next_cnt = carrier_counter - 10'h001; // R11 R13
				next_up  = 1'b0;
			end else begin
				next_cnt = carrier_counter + 10'h001; // R1
			end
		end else begin
			if (carrier_counter == 10'h000) begin
				next_cnt = carrier_counter + 10'h001; // R2 R11
				next_up  = 1'b1;
			end else begin
				next_cnt = carrier_counter - 10'h001;
			end
		end
	end

	assign underflow = tick && next_cnt == 10'h000 && !next_up; // R2
	assign issue     = underflow && (transfer_divider_counter + 3'h1) == irq_div; // R3 R24

	// Carrier counter
	always_ff @(posedge aclk) begin
		if (!aresetn || !counter_enable) begin
			carrier_counter <= 10'h000; // R5
			count_up        <= 1'b1;
		end else if (tick) begin
			carrier_counter <= next_cnt; // R1
			count_up        <= next_up;
		end
	end

	// Transfer divider thins the underflow request
	always_ff @(posedge aclk) begin
		if (!aresetn || !counter_enable || issue) begin
			transfer_divider_counter <= inverter_pwm_pkg::DIV_RST; // R26
		end else if (underflow) begin
			transfer_divider_counter <= transfer_divider_counter + 3'h1; // R26
		end
	end

	// Event requests, registered one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			underflow_irq <= 1'b0;
			event_irq_a   <= 1'b0;
			event_irq_b   <= 1'b0;
		end else begin
			underflow_irq <= issue; // R2 R3
			event_irq_a   <= tick && next_cnt == cmp[4]; // R14
			event_irq_b   <= tick && next_cnt == cmp[5]; // R14
		end
	end

	// Per entry: compare and buffer; the period entry differs in reset and stop
	for (genvar i = 0; i < 6; i++) begin : g_entry
		localparam logic [9:0] RST_VAL = (i == inverter_pwm_pkg::PERIOD_IDX)
			? inverter_pwm_pkg::PERIOD_RST : inverter_pwm_pkg::CMP_RST;

		// Compare: transfer on issue, software write only while stopped
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cmp[i] <= RST_VAL; // R10 R12
			end else if (enable_fall && i != inverter_pwm_pkg::PERIOD_IDX) begin
				cmp[i] <= inverter_pwm_pkg::CMP_RST; // R10
			end else if (issue) begin
				cmp[i] <= cmp_buf[i]; // R7 R9
			end else if (wr_cmp[i] && !counter_enable) begin
				if (w_strb_q[0]) begin
					cmp[i][7:0] <= w_data_q[7:0]; // R8 R9
				end
				if (w_strb_q[1]) begin
					cmp[i][9:8] <= w_data_q[9:8];
				end
			end
		end

		// Buffer: always writable, by byte lane or through the low-byte alias
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cmp_buf[i] <= RST_VAL; // R16
			end else if ((wr_buf[i] || wr_low[i]) && w_strb_q[0]) begin
				cmp_buf[i][7:0] <= w_data_q[7:0]; // R15 R17
				if (wr_buf[i] && w_strb_q[1]) begin
					cmp_buf[i][9:8] <= w_data_q[9:8];
				end
			end else if (wr_buf[i] && w_strb_q[1]) begin
				cmp_buf[i][9:8] <= w_data_q[9:8]; // R17
			end
		end
	end

	// Per phase: flip-flop, dead-time timer and output pair
	for (genvar p = 0; p < 3; p++) begin : g_phase
		dead_time_if link ();
		logic pos_act;
		logic neg_act;

		assign match[p]    = tick && next_cnt == cmp[p]; // R6
		assign link.reload = dead_time_reload; // R18
		assign link.load   = match[p];
		assign link.run    = counter_enable;
		// Both sides wait for the timer, so neither turns on inside the gap
		assign pos_act     = phase_ff[p] && link.idle; // R27
		assign neg_act     = !phase_ff[p] && link.idle; // R27

		dead_time_timer u_timer (
			.aclk    (aclk),
			.aresetn (aresetn),
			.link    (link)
		);

		// Phase flip-flop toggles on every duty match
		always_ff @(posedge aclk) begin
			if (!aresetn || !counter_enable) begin
				phase_ff[p] <= 1'b0;
			end else if (match[p]) begin
				phase_ff[p] <= !phase_ff[p]; // R6
			end
		end

		// Output pair with active level and enable
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				phase_out[2 * p]     <= 1'b0;
				phase_out[2 * p + 1] <= 1'b0;
				phase_oe[2 * p]      <= 1'b0;
				phase_oe[2 * p + 1]  <= 1'b0;
			end else begin
				phase_out[2 * p]     <= active_high ? pos_act : !pos_act; // R22
				phase_out[2 * p + 1] <= active_high ? neg_act : !neg_act; // R22
				phase_oe[2 * p]      <= out_status && counter_enable; // R25
				phase_oe[2 * p + 1]  <= out_status && counter_enable; // R25
			end
		end
	end

	AST_START_UP: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		$rose(counter_enable) |-> carrier_counter == 10'h000 && count_up)
		else $error("counter did not start at zero counting up");

	AST_UNDERFLOW_TURN: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		(underflow |=> carrier_counter == 10'h000 && !count_up)
		and (tick && !count_up && carrier_counter == 10'h000 |=> carrier_counter == 10'h001))
		else $error("counter did not turn upward after underflow");

	AST_DIV_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn) // R26
		issue |=> transfer_divider_counter == 3'h7 && underflow_irq)
		else $error("divider not reloaded to 7 after issued request");

	AST_TRANSFER: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		issue && counter_enable |=> cmp[0] == $past(cmp_buf[0]) && cmp[3] == $past(cmp_buf[3]))
		else $error("buffers not copied on issued underflow request");

	AST_CMP_LOCK: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		counter_enable && !issue |=> $stable(cmp[1]) && $stable(cmp[4]))
		else $error("compare changed while running without transfer");

	AST_PERIOD_LOCK: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		counter_enable && !issue |=> $stable(cmp[3]))
		else $error("period compare changed while running without transfer");

	AST_DTIME_LOCK: assert property (@(posedge aclk) disable iff (!aresetn) // R19
		counter_enable |=> $stable(dead_time_reload))
		else $error("dead-time value changed while running");

	AST_STOP_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		enable_fall |=> cmp[0] == 10'h000 && cmp[5] == 10'h000 && carrier_counter == 10'h000)
		else $error("stop did not clear compares and counter");

	AST_NO_OVERLAP: assert property (@(posedge aclk) disable iff (!aresetn) // R27
		phase_oe[0] && phase_oe[1] && $stable(active_high)
		|-> !(phase_out[0] == active_high && phase_out[1] == active_high))
		else $error("phase pair outputs active together");

	AST_OE_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R25
		!counter_enable |=> phase_oe == 6'h00)
		else $error("outputs driven while stopped");
endmodule
`default_nettype wire

// >>> tb/gate_driver_model.sv
// Gate driver model on the six phase pins, counting overlapping active levels
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model (
	// Clock
	input wire logic       aclk,
	// Phase pins and level setting
	input wire logic [5:0] phase_out,
	input wire logic [5:0] phase_oe,
	input wire logic       active_high,
	// Fault count
	output int             faults
);
	logic [5:0] act;
	logic [5:0] prev_act;
	logic [2:0] bad;
	// A released pin sits at the driver's pull-down and never counts as active
	assign act = phase_oe & ~(phase_out ^ {6{active_high}});
	// Overlap, or one side turning on at the edge the other turns off
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			bad[p] = (act[2*p] & act[2*p+1])
				| (act[2*p] & ~prev_act[2*p] & prev_act[2*p+1])
				| (act[2*p+1] & ~prev_act[2*p+1] & prev_act[2*p]);
		end
	end
	// Gate drivers would shoot through here
	always @(posedge aclk) begin
		prev_act <= act;
		if (bad != 3'h0) faults <= faults + 1;
	end
	initial faults = 0;
endmodule
`default_nettype wire

// >>> tb/inverter_pwm_timer_core_tb_top.sv
// Self-checking bench for the inverter PWM timer core
`timescale 1ns/1ns
`default_nettype none
module inverter_pwm_timer_core_tb_top;
	// Bench drive
	logic        aclk     = 1'b0;
	logic        aresetn  = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h0;
	logic [3:0]  wstrb    = 4'h0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic        shut_pin = 1'b0;
	logic        alv_high = 1'b1;
	// Design outputs
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [5:0]  phase_out, phase_oe;
	logic        uf_irq, ev_a, ev_b;
	int          faults;
	// Bookkeeping
	int          mismatches = 0;
	int          compares   = 0;
	int          cyc, ea, eb;
	logic [31:0] d;

	// Free-running 50 MHz clock
	always #10 aclk = ~aclk;

	inverter_pwm_timer_core i_inverter_pwm_timer_core (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (awaddr),
		.s_axi_awvalid        (awvalid),
		.s_axi_awready        (awready),
		.s_axi_wdata          (wdata),
		.s_axi_wstrb          (wstrb),
		.s_axi_wvalid         (wvalid),
		.s_axi_wready         (wready),
		.s_axi_bresp          (bresp),
		.s_axi_bvalid         (bvalid),
		.s_axi_bready         (bready),
		.s_axi_araddr         (araddr),
		.s_axi_arvalid        (arvalid),
		.s_axi_arready        (arready),
		.s_axi_rdata          (rdata),
		.s_axi_rresp          (rresp),
		.s_axi_rvalid         (rvalid),
		.s_axi_rready         (rready),
		.external_shutoff_pin (shut_pin),
		.phase_out            (phase_out),
		.phase_oe             (phase_oe),
		.underflow_irq        (uf_irq),
		.event_irq_a          (ev_a),
		.event_irq_b          (ev_b)
	);

	gate_driver_model i_gate_driver_model (
		.aclk        (aclk),
		.phase_out   (phase_out),
		.phase_oe    (phase_oe),
		.active_high (alv_high),
		.faults      (faults)
	);

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic give_up;
		mismatches++;
		$display("MISMATCH at %0t: wait ran out", $time);
		wrap_up();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [7:0] at(input logic [7:0] base, input int i);
		return base + 8'(4 * i);
	endfunction

	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf,
		input logic [1:0] er = inverter_pwm_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (awvalid || wvalid || !bvalid) begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (n > 60) give_up();
		end
		bready <= 1'b0;
		chk(32'(bresp), 32'(er), "write response");
	endtask

	// Read: address held until taken, rready held until rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		input logic [1:0] er = inverter_pwm_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (arvalid || !rvalid) begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
			if (n > 60) give_up();
		end
		v = rdata;
		rready <= 1'b0;
		chk(32'(rresp), 32'(er), "read response");
	endtask

	// Counts cycles and event pulses up to the next underflow request
	task automatic wait_irq;
		cyc = 0;
		ea = 0;
		eb = 0;
		do begin
			@(posedge aclk);
			cyc++;
			ea += int'(ev_a === 1'b1);
			eb += int'(ev_b === 1'b1);
			if (cyc > 5000) give_up();
		end while (uf_irq !== 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, i), d);
			chk(d, (i == 3) ? 32'h0ff : 32'h0, "compare reset");
			rd(at(inverter_pwm_pkg::ADDR_BUF_BASE, i), d);
			chk(d, (i == 3) ? 32'h0ff : 32'h0, "buffer reset");
		end
		rd(inverter_pwm_pkg::ADDR_DTIME, d);
		chk(d, 32'hff, "dead time reset");
		// Unmapped place is refused both ways
		wr(8'hfc, 32'h1, 4'hf, inverter_pwm_pkg::RESP_SLVERR);
		rd(8'hfc, d, inverter_pwm_pkg::RESP_SLVERR);
		chk(d, 32'h0, "unmapped read");
		// Writes while stopped land
		wr(at(inverter_pwm_pkg::ADDR_CMP_BASE, 0), 32'h2a5);
		rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, 0), d);
		chk(d, 32'h2a5, "stopped duty write");
		wr(at(inverter_pwm_pkg::ADDR_CMP_BASE, 3), 32'h004);
		rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, 3), d);
		chk(d, 32'h004, "stopped period write");
		wr(inverter_pwm_pkg::ADDR_DTIME, 32'h0);
		rd(inverter_pwm_pkg::ADDR_DTIME, d);
		chk(d, 32'h0, "stopped dead time write");
		// Byte lane and low-byte alias touch bits 7:0 only
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 1), 32'h300);
		wr(at(inverter_pwm_pkg::ADDR_LOW_BASE, 1), 32'h3ab);
		rd(at(inverter_pwm_pkg::ADDR_BUF_BASE, 1), d);
		chk(d, 32'h3ab, "low alias write");
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 2), 32'h3ff);
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 2), 32'h011, 4'h1);
		rd(at(inverter_pwm_pkg::ADDR_BUF_BASE, 2), d);
		chk(d, 32'h311, "byte write");
		// Duty 1, period 4, events at 2 and 4
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 0), 32'h001);
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 3), 32'h004);
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 4), 32'h002);
		wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 5), 32'h004);
		wr(inverter_pwm_pkg::ADDR_MODE, 32'h09);
		chk(32'(phase_oe), 32'h0, "released while stopped");
		// Every divide value, clock selects 0 to 5
		for (int i = 0; i < 8; i++) begin
			wr(inverter_pwm_pkg::ADDR_CTRL, 32'h80 | 32'((i % 6) << 3) | 32'(i));
			wait_irq();
			wait_irq();
			wait_irq();
			chk(32'(cyc), 32'((i + 1) * 8 << (i % 6)), "irq spacing");
			chk(32'(ea), 32'(2 * (i + 1)), "event a count");
			chk(32'(eb), 32'(i + 1), "event b count");
			if (i == 0) begin
				chk(32'(phase_oe), 32'h3f, "driven while running");
				rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, 0), d);
				chk(d, 32'h001, "buffer copied");
				wr(at(inverter_pwm_pkg::ADDR_CMP_BASE, 0), 32'h155);
				rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, 0), d);
				chk(d, 32'h001, "running duty write");
				wr(inverter_pwm_pkg::ADDR_DTIME, 32'h44);
				rd(inverter_pwm_pkg::ADDR_DTIME, d);
				chk(d, 32'h0, "running dead time write");
				wr(at(inverter_pwm_pkg::ADDR_BUF_BASE, 4), 32'h003);
				rd(at(inverter_pwm_pkg::ADDR_BUF_BASE, 4), d);
				chk(d, 32'h003, "running buffer write");
				rd(inverter_pwm_pkg::ADDR_MODE, d);
				chk(d & 32'h10, 32'h10, "output status on");
			end
			wr(inverter_pwm_pkg::ADDR_CTRL, 32'(i));
			rd(inverter_pwm_pkg::ADDR_STAT, d);
			chk(d & 32'h3ff, 32'h0, "counter cleared");
			rd(at(inverter_pwm_pkg::ADDR_CMP_BASE, 4), d);
			chk(d, 32'h0, "event compare cleared");
			chk(32'(phase_oe), 32'h0, "released on stop");
		end
		// Shut-off pin edge releases every pin
		wr(inverter_pwm_pkg::ADDR_CTRL, 32'h80);
		wait_irq();
		chk(32'(phase_oe), 32'h3f, "driven before shut-off");
		shut_pin <= 1'b1;
		cyc = 0;
		while (phase_oe !== 6'h00 && cyc < 20) begin
			@(posedge aclk);
			cyc++;
		end
		chk(32'(phase_oe), 32'h0, "shut-off release");
		rd(inverter_pwm_pkg::ADDR_MODE, d);
		chk(d & 32'h10, 32'h0, "output status off");
		chk(32'(faults), 32'h0, "pair overlap");
		wrap_up();
	end
endmodule
`default_nettype wire
